/* File: logic/bbc_backlight_ctrl.sv */
`timescale 1ns/10ps
// Function
// - Select 00: start/stop at enable, run-time otherwise
// - Select 01: start/stop times for everything
// - Select 1x: start/stop at enable, level changes immediate once running
// - One mapping mode shared by both banks
// - Exponential 8-bit law scaled by duty
// - Exponential 11-bit uses code divided by 8
// - Linear 8-bit uses code over 255
// - Linear 11-bit uses code over 2047
// - Fault flags gated by fault enable bits
// - Open: sink low while at overvoltage limit
// - No feedback means no open fault
// - Open flags in bits 2:0 per string
// - Short: enabled sink with short comparator
// - Short flag in bit 0
// - Four overvoltage limits, default 16 V
// - Stop switching at limit, resume 1 V below
// - Overcurrent cuts switch for rest of cycle
// - Detect start, stop and bus busy
// - Repeated start handled like start
// - Lower byte reaches level on upper write, code_11bit at once
// - Respond to target address 0110110
`include "bbc_defines.svh"
module bbc_backlight_ctrl
   import bbc_pkg::*;
#(
   parameter int P_CYC_PER_US = `BBC_CYC_PER_US
) (
   // Clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_reset,
   // Serial port
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_out,
   output logic            o_sda_oe,
   output logic            o_bus_busy,
   // Analog sense
   input  wire bbc_sense_s i_sense,
   // Boost control
   output logic            o_switch_on_allow,
   output logic [1:0]      o_ovp_select,
   // Sinks and banks
   output logic [2:0]      o_sink_enable,
   output logic [2:0]      o_sink_bank_b,
   output logic            o_map_exponential,
   output bbc_bank_s       o_bank_a,
   output bbc_bank_s       o_bank_b
);
   localparam int NSYNC = $bits(bbc_sense_s) + 2;

   // Three-stage sync and agreement filter
   logic [NSYNC-1:0] sync1, sync2, sync3, filt;
   always_ff @(posedge i_clk_sys) begin
      sync1 <= {i_scl, i_sda, i_sense};
      sync2 <= sync1;
      sync3 <= sync2;
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         filt <= {2'b11, {($bits(bbc_sense_s)){1'b0}}};
      end else begin
         for (int k = 0; k < NSYNC; k++) begin
            if (sync2[k] == sync3[k]) begin
               filt[k] <= sync3[k];
            end
         end
      end
   end
   bbc_sense_s sense;
   logic       scl, sda, scl_d, sda_d, cyc_d;
   assign scl   = filt[NSYNC-1];
   assign sda   = filt[NSYNC-2];
   assign sense = filt[NSYNC-3:0];
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         cyc_d <= 1'b0;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
         cyc_d <= sense.cycle_clk;
      end
   end
   logic start_c, stop_c, scl_rise, scl_fall, cyc_start;
   assign start_c   = scl & scl_d & sda_d & ~sda;
   assign stop_c    = scl & scl_d & ~sda_d & sda;
   assign scl_rise  = scl & ~scl_d;
   assign scl_fall  = ~scl & scl_d;
   assign cyc_start = sense.cycle_clk & ~cyc_d;

   // Registers
   logic [7:0] sink_bank_assignment, run_ramp_times, ramp_select, map_config;
   logic [7:0] sink_feedback_enables, boost_config, bank_enables;
   logic [7:0] string_fault_enables, open_string_flags, short_string_flags;
   logic [7:0] start_stop_ramp [2];
   logic [7:0] full_scale      [2];
   logic [7:0] level_upper     [2];
   logic [2:0] level_lower     [2];
   logic [10:0] target         [2];

   // Serial engine
   bbc_ser_e   state;
   logic [3:0] bitcnt;
   logic [7:0] shreg, ptr;
   logic       drive_low, nack, wr_pulse;

   function automatic logic [7:0] reg_read(input logic [7:0] a);
      unique case (a)
         `BBC_REG_SINK_BANK: reg_read = sink_bank_assignment;
         `BBC_REG_SSR_A:     reg_read = start_stop_ramp[0];
         `BBC_REG_SSR_B:     reg_read = start_stop_ramp[1];
         `BBC_REG_RT_RAMP:   reg_read = run_ramp_times;
         `BBC_REG_RAMP_SEL:  reg_read = ramp_select;
         `BBC_REG_MAP_CFG:   reg_read = map_config;
         `BBC_REG_FS_A:      reg_read = full_scale[0];
         `BBC_REG_FS_B:      reg_read = full_scale[1];
         `BBC_REG_FB_EN:     reg_read = sink_feedback_enables;
         `BBC_REG_BOOST:     reg_read = boost_config;
         `BBC_REG_LSB_A:     reg_read = {5'h00, level_lower[0]};
         `BBC_REG_MSB_A:     reg_read = level_upper[0];
         `BBC_REG_LSB_B:     reg_read = {5'h00, level_lower[1]};
         `BBC_REG_MSB_B:     reg_read = level_upper[1];
         `BBC_REG_BANK_EN:   reg_read = bank_enables;
         `BBC_REG_OPEN:      reg_read = open_string_flags;
         `BBC_REG_SHORT:     reg_read = short_string_flags;
         `BBC_REG_FAULT_EN:  reg_read = string_fault_enables;
         default:            reg_read = 8'h00;
      endcase
   endfunction

   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = reg_read(ptr);
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state     <= BBC_IDLE;
         bitcnt    <= 4'h0;
         shreg     <= 8'h00;
         ptr       <= 8'h00;
         drive_low <= 1'b0;
         nack      <= 1'b0;
         wr_pulse  <= 1'b0;
      end else begin
         wr_pulse <= 1'b0;
         if (start_c) begin
            state     <= BBC_ADDR;
            bitcnt    <= 4'hF; // First fall after start is not a bit
            drive_low <= 1'b0;
         end else if (stop_c) begin
            state     <= BBC_IDLE;
            drive_low <= 1'b0;
         end else if (state != BBC_IDLE && scl_rise) begin
            if (bitcnt < 4'h8) begin
               if (state != BBC_RDATA) begin
                  shreg <= {shreg[6:0], sda};
               end
            end else begin
               nack <= sda;
            end
         end else if (state != BBC_IDLE && scl_fall) begin
            if (bitcnt < 4'h7 || bitcnt == 4'hF) begin
               bitcnt <= bitcnt + 4'h1;
               if (state == BBC_RDATA) begin
                  drive_low <= ~shreg[3'(6 - bitcnt)];
               end
            end else if (bitcnt == 4'h7) begin
               bitcnt <= 4'h8;
               unique case (state)
                  BBC_ADDR:  drive_low <= (shreg[7:1] == `BBC_DEV_ADDR);
                  BBC_REG:   drive_low <= 1'b1;
                  BBC_WDATA: begin
                     drive_low <= 1'b1;
                     wr_pulse  <= 1'b1;
                  end
                  default:   drive_low <= 1'b0;
               endcase
            end else begin
               bitcnt    <= 4'h0;
               drive_low <= 1'b0;
               unique case (state)
                  BBC_ADDR: begin
                     if (shreg[7:1] != `BBC_DEV_ADDR) begin
                        state <= BBC_IDLE;
                     end else if (shreg[0]) begin
                        state     <= BBC_RDATA;
                        shreg     <= rd_byte;
                        drive_low <= ~rd_byte[7];
                        ptr       <= ptr + 8'h01;
                     end else begin
                        state <= BBC_REG;
                     end
                  end
                  BBC_REG: begin
                     ptr   <= shreg;
                     state <= BBC_WDATA;
                  end
                  BBC_WDATA: ptr <= ptr + 8'h01;
                  BBC_RDATA: begin
                     if (nack) begin
                        state <= BBC_IDLE;
                     end else begin
                        shreg     <= rd_byte;
                        drive_low <= ~rd_byte[7];
                        ptr       <= ptr + 8'h01;
                     end
                  end
                  default: state <= BBC_IDLE;
               endcase
            end
         end
      end
   end
   assign o_sda_out  = 1'b0;
   assign o_sda_oe   = drive_low;
   assign o_bus_busy = (state != BBC_IDLE);

   // Register writes
   logic [7:0] en_rise;
   assign en_rise = (wr_pulse && ptr == `BBC_REG_BANK_EN) ? (shreg & ~bank_enables) : 8'h00;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         sink_bank_assignment  <= `BBC_RST_SINK_BANK;
         run_ramp_times        <= 8'h00;
         ramp_select           <= 8'h00;
         map_config            <= 8'h00;
         sink_feedback_enables <= `BBC_RST_FB_EN;
         boost_config          <= 8'h00;
         bank_enables          <= 8'h00;
         string_fault_enables  <= 8'h00;
         for (int b = 0; b < 2; b++) begin
            start_stop_ramp[b] <= 8'h00;
            full_scale[b]      <= `BBC_RST_FS;
            level_upper[b]     <= 8'h00;
            level_lower[b]     <= 3'h0;
            target[b]          <= 11'h000;
         end
      end else if (wr_pulse) begin
         unique case (ptr)
            `BBC_REG_SINK_BANK: sink_bank_assignment <= shreg;
            `BBC_REG_SSR_A:     start_stop_ramp[0] <= shreg;
            `BBC_REG_SSR_B:     start_stop_ramp[1] <= shreg;
            `BBC_REG_RT_RAMP:   run_ramp_times <= shreg;
            `BBC_REG_RAMP_SEL:  ramp_select <= shreg;
            `BBC_REG_MAP_CFG:   map_config <= shreg;
            `BBC_REG_FS_A:      full_scale[0] <= shreg;
            `BBC_REG_FS_B:      full_scale[1] <= shreg;
            `BBC_REG_FB_EN:     sink_feedback_enables <= shreg;
            `BBC_REG_BOOST:     boost_config <= shreg;
            `BBC_REG_LSB_A:     level_lower[0] <= shreg[2:0];
            `BBC_REG_LSB_B:     level_lower[1] <= shreg[2:0];
            `BBC_REG_MSB_A: begin
               level_upper[0] <= shreg;
               target[0]      <= {shreg, level_lower[0]};
            end
            `BBC_REG_MSB_B: begin
               level_upper[1] <= shreg;
               target[1]      <= {shreg, level_lower[1]};
            end
            `BBC_REG_BANK_EN:   bank_enables <= shreg;
            `BBC_REG_FAULT_EN:  string_fault_enables <= shreg;
            default:            ;
         endcase
      end
   end

   // Ramp step length in microseconds per code
   function automatic logic [15:0] step_us(input logic [3:0] c);
      unique case (c)
         4'h0: step_us = 16'h0001;
         4'h1: step_us = 16'h0080;
         4'h2: step_us = 16'h0100;
         4'h3: step_us = 16'h0200;
         4'h4: step_us = 16'h0400;
         4'h5: step_us = 16'h0800;
         4'h6: step_us = 16'h1000;
         4'h7: step_us = 16'h2000;
         4'h8: step_us = 16'h4000;
         4'h9: step_us = 16'h5000;
         4'hA: step_us = 16'h6000;
         4'hB: step_us = 16'h7000;
         4'hC: step_us = 16'h8000;
         4'hD: step_us = 16'hA000;
         4'hE: step_us = 16'hC000;
         4'hF: step_us = 16'hE000;
      endcase
   endfunction

   // Per-bank ramp engine
   logic [10:0] level [2];
   logic [1:0]  run;
   logic [1:0]  bank_on;
   assign bank_on = bank_enables[1:0];
   for (genvar b = 0; b < 2; b++) begin : g_bank
      logic [10:0] goal;
      logic [23:0] tmr;
      logic [3:0]  tcode;
      logic        up, instant;
      logic [1:0]  sel;
      assign sel  = ramp_select[2*b +: 2];
      assign goal = bank_on[b] ? target[b] : 11'h000;
      assign up   = goal > level[b];
      always_comb begin
         tcode = start_stop_ramp[b][3:0];
         if (!bank_on[b]) begin
            tcode = start_stop_ramp[b][3:0];
         end else if (!run[b]) begin
            tcode = start_stop_ramp[b][7:4];
         end else if (sel == 2'b00) begin
            tcode = up ? run_ramp_times[7:4] : run_ramp_times[3:0];
         end else begin
            tcode = up ? start_stop_ramp[b][7:4] : start_stop_ramp[b][3:0];
         end
      end
      assign instant = bank_on[b] & run[b] & sel[1];
      always_ff @(posedge i_clk_sys) begin
         if (i_reset) begin
            level[b] <= 11'h000;
            run[b]   <= 1'b0;
            tmr      <= 24'h000000;
         end else begin
            if (!bank_on[b]) begin
               run[b] <= 1'b0;
            end else if (level[b] == goal) begin
               run[b] <= 1'b1;
            end
            if (instant) begin
               level[b] <= goal;
               tmr      <= 24'h000000;
            end else if (level[b] == goal) begin
               tmr <= 24'h000000;
            end else if (tmr == 24'h000000) begin
               level[b] <= up ? level[b] + 11'h001 : level[b] - 11'h001;
               tmr      <= 24'(step_us(tcode) * P_CYC_PER_US - 1);
            end else begin
               tmr <= tmr - 24'h000001;
            end
         end
      end
   end

   // Bank outputs; law and duty scaling applied by the sink DAC
   assign o_map_exponential   = map_config[`BBC_MAP_EXP_BIT];
   assign o_bank_a.full_scale = full_scale[0];
   assign o_bank_a.level      = level[0];
   assign o_bank_a.code_11bit = (level_lower[0] != 3'h0);
   assign o_bank_a.enabled    = bank_on[0];
   assign o_bank_b.full_scale = full_scale[1];
   assign o_bank_b.level      = level[1];
   assign o_bank_b.code_11bit = (level_lower[1] != 3'h0);
   assign o_bank_b.enabled    = bank_on[1];
   assign o_sink_bank_b       = sink_bank_assignment[2:0];
   for (genvar s = 0; s < 3; s++) begin : g_sink
      assign o_sink_enable[s] = sink_bank_assignment[s] ? bank_on[1] : bank_on[0];
   end

   // Fault flags
   logic [2:0] open_set;
   logic       short_set, flt_clr;
   assign open_set  = {3{string_fault_enables[`BBC_FLT_OPEN_BIT] & sense.ovp_reach}}
                      & o_sink_enable & sink_feedback_enables[2:0] & sense.sink_low;
   assign short_set = string_fault_enables[`BBC_FLT_SHORT_BIT]
                      & |(o_sink_enable & sense.short_det);
   assign flt_clr   = |en_rise[1:0];
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         open_string_flags  <= 8'h00;
         short_string_flags <= 8'h00;
      end else begin
         open_string_flags  <= {5'h00, (flt_clr ? 3'h0 : open_string_flags[2:0]) | open_set};
         short_string_flags <= {7'h00, (~flt_clr & short_string_flags[0]) | short_set};
      end
   end

   // Boost gating
   logic ovp_hold, ocp_off;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         ovp_hold <= 1'b0;
         ocp_off  <= 1'b0;
      end else begin
         if (sense.ovp_reach) begin
            ovp_hold <= 1'b1;
         end else if (sense.ovp_release) begin
            ovp_hold <= 1'b0;
         end
         if (sense.ocp_trip) begin
            ocp_off <= 1'b1;
         end else if (cyc_start) begin
            ocp_off <= 1'b0;
         end
      end
   end
   assign o_switch_on_allow = |bank_on & ~ovp_hold & ~ocp_off;
   assign o_ovp_select      = boost_config[`BBC_OVP_HI:`BBC_OVP_LO];

   // Checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   a_ovp_stops_switch: assert property (ovp_hold |-> !o_switch_on_allow)
      else $error("switching while overvoltage hold");
   a_ovp_hyst_hold: assert property (ovp_hold && !sense.ovp_release |=> ovp_hold)
      else $error("overvoltage hold released early");
   a_ocp_cycle_off: assert property (sense.ocp_trip |=> !o_switch_on_allow)
      else $error("switch on after overcurrent");
   a_start_busy: assert property (start_c |=> o_bus_busy)
      else $error("bus not busy after start");
   a_stop_free: assert property (stop_c |=> !o_bus_busy)
      else $error("bus busy after stop");
   a_lsb_no_effect: assert property (wr_pulse && ptr == `BBC_REG_LSB_A
                                     |=> $stable(target[0]))
      else $error("lower byte changed level");
   a_open_gated: assert property (!string_fault_enables[0] && !flt_clr
                                  |=> $stable(open_string_flags))
      else $error("open flag changed while disabled");
   a_open_needs_fb: assert property (!sink_feedback_enables[1]
                                     && $past(flt_clr) |-> !open_string_flags[1])
      else $error("open flag without feedback");
   a_flags_hold: assert property (open_string_flags[0] && !flt_clr
                                  |=> open_string_flags[0])
      else $error("open flag lost");
   a_instant_step: assert property (g_bank[0].instant && level[0] != g_bank[0].goal
                                    |=> level[0] == $past(g_bank[0].goal))
      else $error("immediate mode ramped");
   a_addr_ack: assert property (state == BBC_ADDR && scl_fall && bitcnt == 4'h7
                                && shreg[7:1] == `BBC_DEV_ADDR |=> o_sda_oe)
      else $error("no ack of own address");
   c_write: cover property (wr_pulse && ptr == `BBC_REG_MSB_A);
   c_read: cover property (state == BBC_RDATA && scl_fall);
   c_open: cover property (open_string_flags[2:0] != 3'h0);
   c_ocp: cover property (ocp_off ##[1:50] !ocp_off);
endmodule

/* File: logic/bbc_defines.svh */
`ifndef BBC_DEFINES_SVH
`define BBC_DEFINES_SVH
// Serial target address
`define BBC_DEV_ADDR      7'h36
// Register offsets
`define BBC_REG_SINK_BANK 8'h10
`define BBC_REG_SSR_A     8'h11
`define BBC_REG_SSR_B     8'h12
`define BBC_REG_RT_RAMP   8'h13
`define BBC_REG_RAMP_SEL  8'h14
`define BBC_REG_MAP_CFG   8'h16
`define BBC_REG_FS_A      8'h17
`define BBC_REG_FS_B      8'h18
`define BBC_REG_FB_EN     8'h19
`define BBC_REG_BOOST     8'h1A
`define BBC_REG_LSB_A     8'h20
`define BBC_REG_MSB_A     8'h21
`define BBC_REG_LSB_B     8'h22
`define BBC_REG_MSB_B     8'h23
`define BBC_REG_BANK_EN   8'h24
`define BBC_REG_OPEN      8'hB0
`define BBC_REG_SHORT     8'hB2
`define BBC_REG_FAULT_EN  8'hB4
// Reset values
`define BBC_RST_SINK_BANK 8'h06
`define BBC_RST_FS        8'h13
`define BBC_RST_FB_EN     8'h07
// Field positions
`define BBC_FLT_OPEN_BIT  0
`define BBC_FLT_SHORT_BIT 1
`define BBC_MAP_EXP_BIT   0
`define BBC_OVP_LO        1
`define BBC_OVP_HI        2
// Timing: clock period in ns, ramp unit in us
`define BBC_CLK_NS        4
`define BBC_RAMP_UNIT_US  1
`define BBC_CYC_PER_US    (1000 * `BBC_RAMP_UNIT_US / `BBC_CLK_NS)
`endif

/* File: logic/bbc_pkg.sv */
package bbc_pkg;
   typedef enum logic [2:0] {
      BBC_IDLE  = 3'b000,
      BBC_ADDR  = 3'b001,
      BBC_REG   = 3'b010,
      BBC_WDATA = 3'b011,
      BBC_RDATA = 3'b100
   } bbc_ser_e;

   typedef struct packed {
      logic [7:0]  full_scale;
      logic [10:0] level;
      logic        code_11bit;
      logic        enabled;
   } bbc_bank_s;

   typedef struct packed {
      logic       ovp_reach;
      logic       ovp_release;
      logic       ocp_trip;
      logic       cycle_clk;
      logic [2:0] sink_low;
      logic [2:0] short_det;
   } bbc_sense_s;
endpackage

/* File: test/bbc_host_model.sv */
`timescale 1ns/10ps
module bbc_host_model #(
   parameter int P_Q = 16
) (
   // Bus pins
   output logic      o_scl,
   output logic      o_sda_low,
   input  wire logic i_sda
);
   initial begin
      o_scl     = 1'b1;
      o_sda_low = 1'b0;
   end
   // Start and repeated start alike
   task automatic start();
      o_sda_low = 1'b0;
      #P_Q o_scl = 1'b1;
      #(2 * P_Q) o_sda_low = 1'b1;
      #(2 * P_Q) o_scl = 1'b0;
      #P_Q;
   endtask
   task automatic stop();
      o_sda_low = 1'b1;
      #P_Q o_scl = 1'b1;
      #(2 * P_Q) o_sda_low = 1'b0;
      #(2 * P_Q);
   endtask
   // Nine bits MSB first, data moved only while clock low
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         o_sda_low = ~d[i];
         #P_Q o_scl = 1'b1;
         #P_Q q[i] = i_sda;
         #P_Q o_scl = 1'b0;
         #P_Q;
      end
   endtask
endmodule

/* File: test/bbc_backlight_ctrl_tb_top.sv */
`timescale 1ns/10ps
module bbc_backlight_ctrl_tb_top;
   import bbc_pkg::*;
   logic       i_clk_sys;
   logic       i_reset;
   logic       scl;
   logic       sda_low;
   wire        sda;
   logic       sda_oe;
   logic       busy;
   logic       allow;
   logic [1:0] ovp_sel;
   logic [2:0] sink_en;
   logic [2:0] sink_b;
   logic       map_exp;
   bbc_bank_s  bank_a;
   bbc_bank_s  bank_b;
   bbc_sense_s sense;
   int         fails;
   int         n_checks;
   int         cycles;
   logic [7:0] d;
   logic [2:0] lo;
   logic [8:0] q9;
   logic [7:0] mdl [logic [7:0]];
   // Pull-up on the data line
   assign sda = ~(sda_low | sda_oe);
   always #2 i_clk_sys = ~i_clk_sys;
   bbc_host_model H (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
   bbc_backlight_ctrl #(.P_CYC_PER_US(1)) DUT (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_scl(scl), .i_sda(sda),
      .o_sda_out(), .o_sda_oe(sda_oe), .o_bus_busy(busy), .i_sense(sense),
      .o_switch_on_allow(allow), .o_ovp_select(ovp_sel), .o_sink_enable(sink_en),
      .o_sink_bank_b(sink_b), .o_map_exponential(map_exp), .o_bank_a(bank_a),
      .o_bank_b(bank_b)
   );
   task automatic conclude();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task automatic snd(input logic [7:0] b);
      logic [8:0] q;
      H.xfer({b, 1'b1}, q);
      chk("ack", 11'h000, {10'h000, q[0]});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      H.start();
      snd(8'h6C);
      snd(a);
      snd(v);
      H.stop();
      mdl[a] = v;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [8:0] q;
      H.start();
      snd(8'h6C);
      snd(a);
      H.start();
      snd(8'h6D);
      H.xfer(9'h1FF, q);
      H.stop();
      chk("read", {3'h0, e}, {3'h0, q[8:1]});
   endtask
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 80000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      i_clk_sys = 1'b0;
      i_reset   = 1'b1;
      sense     = '0;
      fails     = 0;
      n_checks  = 0;
      cycles    = 0;
      void'($urandom(36));
      cyc(3);
      i_reset = 1'b0;
      chk("sink_bank_b", 11'h006, {8'h00, sink_b});
      chk("ovp_select", 11'h000, {9'h000, ovp_sel});
      chk("full_scale", 11'h013, {3'h0, bank_a.full_scale});
      chk("full_scale_b", 11'h013, {3'h0, bank_b.full_scale});
      cyc(8);
      H.start();
      chk("busy", 11'h001, {10'h000, busy});
      H.xfer({8'h6E, 1'b1}, q9);
      chk("nack", 11'h001, {10'h000, q9[0]});
      H.stop();
      cyc(8);
      chk("busy", 11'h000, {10'h000, busy});
      rd(8'h10, 8'h06);
      rd(8'h19, 8'h07);
      rd(8'hB4, 8'h00);
      rd(8'h30, 8'h00);
      for (int k = 0; k < 2; k++) begin
         d = 8'($urandom);
         wr(8'(8'h17 + k), d);
         rd(8'(8'h17 + k), mdl[8'(8'h17 + k)]);
      end
      chk("full_scale_b", {3'h0, mdl[8'h18]}, {3'h0, bank_b.full_scale});
      for (int k = 0; k < 4; k++) begin
         wr(8'h1A, 8'(k << 1));
         chk("ovp_select", 11'(k), {9'h000, ovp_sel});
      end
      wr(8'h16, 8'h01);
      chk("map", 11'h001, {10'h000, map_exp});
      wr(8'h16, 8'h00);
      chk("map", 11'h000, {10'h000, map_exp});
      wr(8'hB4, 8'h01);
      wr(8'h10, 8'h00);
      wr(8'h11, 8'h00);
      wr(8'h19, 8'h05);
      wr(8'h14, 8'h02);
      wr(8'h21, 8'hFF);
      sense.sink_low  = 3'b111;
      sense.short_det = 3'b001;
      sense.ovp_reach = 1'b1;
      wr(8'h24, 8'h01);
      cyc(20);
      chk("sink_enable", 11'h007, {8'h00, sink_en});
      chk("allow", 11'h000, {10'h000, allow});
      rd(8'hB0, 8'h05);
      rd(8'hB2, 8'h00);
      sense.ovp_reach = 1'b0;
      cyc(20);
      chk("allow", 11'h000, {10'h000, allow});
      sense.ovp_release = 1'b1;
      cyc(20);
      chk("allow", 11'h001, {10'h000, allow});
      rd(8'hB0, 8'h05);
      sense.ocp_trip = 1'b1;
      cyc(4);
      sense.ocp_trip = 1'b0;
      cyc(10);
      chk("allow", 11'h000, {10'h000, allow});
      sense.cycle_clk = 1'b1;
      cyc(10);
      chk("allow", 11'h001, {10'h000, allow});
      sense.cycle_clk = 1'b0;
      wr(8'h24, 8'h00);
      wr(8'hB4, 8'h02);
      wr(8'h10, 8'h06);
      wr(8'h24, 8'h01);
      cyc(20);
      chk("sink_enable", 11'h001, {8'h00, sink_en});
      rd(8'hB2, 8'h01);
      rd(8'hB0, 8'h00);
      cyc(2200);
      chk("level", 11'h7F8, bank_a.level);
      lo = 3'($urandom_range(7, 1));
      wr(8'h20, {5'h00, lo});
      chk("level", 11'h7F8, bank_a.level);
      wr(8'h21, 8'h40);
      chk("level", {8'h40, lo}, bank_a.level);
      chk("code_11bit", 11'h001, {10'h000, bank_a.code_11bit});
      wr(8'h13, 8'h00);
      wr(8'h11, 8'h10);
      wr(8'h14, 8'h00);
      wr(8'h21, 8'h41);
      cyc(40);
      chk("level", {8'h41, lo}, bank_a.level);
      wr(8'h14, 8'h01);
      wr(8'h21, 8'h42);
      chk("ramping", 11'h001, {10'h000, bank_a.level < {8'h42, lo}});
      cyc(1400);
      chk("level", {8'h42, lo}, bank_a.level);
      conclude();
   end
endmodule
